/* core/pic_defines.svh */
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register addressing on the address pin
// ---------------------------------------------------------------------------
`define PIC_ADDR_STATUS    1'h0
`define PIC_ADDR_MASK      1'h1

// ---------------------------------------------------------------------------
// Acknowledge sequence contents
// ---------------------------------------------------------------------------
`define PIC_CALL_OPCODE    8'hcd
`define PIC_ACK85_PULSES   2'h3
`define PIC_ACK86_PULSES   2'h2
`define PIC_SPURIOUS_LEVEL 3'h7

// ---------------------------------------------------------------------------
// Pin timing
// ---------------------------------------------------------------------------
`define PIC_CLK_NS         4
`define PIC_SETUP_NS       40
`define PIC_STROBE_NS      160
`define PIC_HOLD_NS        20
`define PIC_RECOV_NS       160
`define PIC_SETUP_CYC      ((`PIC_SETUP_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`define PIC_STROBE_CYC     ((`PIC_STROBE_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`define PIC_HOLD_CYC       ((`PIC_HOLD_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)
`define PIC_RECOV_CYC      ((`PIC_RECOV_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)

`endif

/* core/pic_pkg.sv */
package pic_pkg;

  typedef enum logic [1:0] {
    pic_cmd_read,
    pic_cmd_write,
    pic_cmd_ack85,
    pic_cmd_ack86
  } pic_cmd_e;

  typedef enum logic [2:0] {
    pic_st_idle,
    pic_st_setup,
    pic_st_strobe,
    pic_st_hold,
    pic_st_recov
  } pic_state_e;

endpackage : pic_pkg

/* core/pic_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pic_defines.svh"

// What this block does
// - 85 mode: first acknowledge returns call opcode
// - 85 mode: two more pulses, low then high
// - Otherwise software sends end-of-service command
// - 86 mode: second pulse returns vector byte
module pic_host (
  input  wire logic              mclk,        // Controller clock
  input  wire logic              rst,         // Synchronous reset, high
  input  wire logic              cmd_valid,   // Command offered
  input  wire pic_pkg::pic_cmd_e cmd_kind,    // Read, write or acknowledge sequence
  input  wire logic              cmd_addr,    // Address pin value for the access
  input  wire logic [7:0]        cmd_wdata,   // Write byte
  output logic                   cmd_ready,   // Ready for a command
  output logic                   rsp_valid,   // One-cycle byte returned
  output logic [7:0]             rsp_data,    // Returned byte
  output logic [1:0]             rsp_index,   // Byte position in the sequence
  output logic                   int_seen,    // Registered interrupt line
  output logic                   cs_n,        // Chip select pin
  output logic                   rd_n,        // Read strobe pin
  output logic                   wr_n,        // Write strobe pin
  output logic                   addr_lsb,    // Address pin
  output logic                   ack_n,       // Acknowledge strobe pin
  input  wire logic [7:0]        d_in,        // Data bus level
  output logic [7:0]             d_out,       // Data bus drive value
  output logic                   d_oe_n,      // Data bus enable, low drives
  input  wire logic              int_in       // Device interrupt output
);
  import pic_pkg::*;

  // -------------------------------------------------------------------------
  // Sequencer state
  // -------------------------------------------------------------------------
  pic_state_e state, next_state;
  pic_cmd_e   kind, next_kind;
  logic [7:0] cnt, next_cnt;
  logic [1:0] pulse, next_pulse;
  logic       next_cmd_ready, next_rsp_valid;
  logic [7:0] next_rsp_data;
  logic [1:0] next_rsp_index;
  logic       next_cs_n, next_rd_n, next_wr_n, next_addr_lsb, next_ack_n, next_d_oe_n;
  logic [7:0] next_d_out;
  logic       is_ack;
  logic [1:0] last_pulse;

  always_comb begin
    is_ack     = (kind == pic_cmd_ack85) || (kind == pic_cmd_ack86);
    last_pulse = (kind == pic_cmd_ack85) ? `PIC_ACK85_PULSES - 2'h1
                                         : `PIC_ACK86_PULSES - 2'h1;
    next_state     = state;
    next_kind      = kind;
    next_cnt       = cnt;
    next_pulse     = pulse;
    next_cmd_ready = cmd_ready;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    next_rsp_index = rsp_index;
    next_cs_n      = cs_n;
    next_rd_n      = rd_n;
    next_wr_n      = wr_n;
    next_addr_lsb  = addr_lsb;
    next_ack_n     = ack_n;
    next_d_out     = d_out;
    next_d_oe_n    = d_oe_n;
    unique case (state)
      pic_st_idle: begin
        if (cmd_valid) begin
          next_kind      = cmd_kind;
          next_pulse     = 2'h0;
          next_cmd_ready = 1'b0;
          next_cnt       = 8'(`PIC_SETUP_CYC - 1);
          next_state     = pic_st_setup;
          if (cmd_kind == pic_cmd_read || cmd_kind == pic_cmd_write) begin
            // The address pin picks status or mask on reads and the
            // command word group on writes.
            next_cs_n     = 1'b0;
            next_addr_lsb = cmd_addr;
          end
          if (cmd_kind == pic_cmd_write) begin
            // Bits 4 and 3 of the byte choose the command word at address 0.
            // End-of-service commands are ordinary writes of the raw byte.
            next_d_out  = cmd_wdata;
            next_d_oe_n = 1'b0;
          end
        end
      end
      pic_st_setup: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_cnt   = 8'(`PIC_STROBE_CYC - 1);
          next_state = pic_st_strobe;
          // Only one strobe is ever taken low at a time.
          unique case (kind)
            pic_cmd_read:  next_rd_n  = 1'b0;
            pic_cmd_write: next_wr_n  = 1'b0;
            pic_cmd_ack85: next_ack_n = 1'b0;
            pic_cmd_ack86: next_ack_n = 1'b0;
          endcase
        end
      end
      pic_st_strobe: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          // Data is taken in the last cycle before the strobe rises, when
          // the device has had the full strobe width to settle it.
          if (kind == pic_cmd_read || kind == pic_cmd_ack85) begin
            next_rsp_valid = 1'b1;
            next_rsp_data  = d_in;
            next_rsp_index = pulse;
          end
          if (kind == pic_cmd_ack86 && pulse != 2'h0) begin
            next_rsp_valid = 1'b1;
            next_rsp_data  = d_in;
            next_rsp_index = pulse - 2'h1;
          end
          next_rd_n  = 1'b1;
          next_wr_n  = 1'b1;
          next_ack_n = 1'b1;
          next_cnt   = 8'(`PIC_HOLD_CYC - 1);
          next_state = pic_st_hold;
        end
      end
      pic_st_hold: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          // Releasing the bus here leaves it free for the device.
          next_cs_n   = 1'b1;
          next_d_oe_n = 1'b1;
          next_cnt    = 8'(`PIC_RECOV_CYC - 1);
          next_state  = pic_st_recov;
        end
      end
      pic_st_recov: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          if (is_ack && pulse != last_pulse) begin
            // Further acknowledge pulses follow without a select phase.
            next_pulse = pulse + 2'h1;
            next_ack_n = 1'b0;
            next_cnt   = 8'(`PIC_STROBE_CYC - 1);
            next_state = pic_st_strobe;
          end else begin
            next_cmd_ready = 1'b1;
            next_state     = pic_st_idle;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state     <= pic_st_idle;
      kind      <= pic_cmd_read;
      cnt       <= 8'h00;
      pulse     <= 2'h0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_index <= 2'h0;
      cs_n      <= 1'b1;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      addr_lsb  <= 1'b0;
      ack_n     <= 1'b1;
      d_out     <= 8'h00;
      d_oe_n    <= 1'b1;
    end else begin
      state     <= next_state;
      kind      <= next_kind;
      cnt       <= next_cnt;
      pulse     <= next_pulse;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
      rsp_index <= next_rsp_index;
      cs_n      <= next_cs_n;
      rd_n      <= next_rd_n;
      wr_n      <= next_wr_n;
      addr_lsb  <= next_addr_lsb;
      ack_n     <= next_ack_n;
      d_out     <= next_d_out;
      d_oe_n    <= next_d_oe_n;
    end
  end

  // -------------------------------------------------------------------------
  // Interrupt line
  // -------------------------------------------------------------------------
  logic next_int_seen;

  always_comb begin
    next_int_seen = int_in;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      int_seen <= 1'b0;
    end else begin
      int_seen <= next_int_seen;
    end
  end

endmodule : pic_host

`default_nettype wire

/* dv/pic_host_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_host_checker (
  input wire logic       mclk,      // Clock.
  input wire logic       rst,       // Reset.
  input wire logic       cs_n,      // Select.
  input wire logic       rd_n,      // Read.
  input wire logic       wr_n,      // Write.
  input wire logic       ack_n,     // Acknowledge.
  input wire logic       d_oe_n,    // Bus enable.
  input wire logic       rsp_valid, // Byte out.
  input wire logic [1:0] rsp_index  // Byte slot.
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rdwr; !(!rd_n && !wr_n); endproperty
  a_rdwr: assert property (p_rdwr) else $error("rd wr overlap");
  property p_ackcs; !ack_n |-> cs_n && d_oe_n; endproperty
  a_ackcs: assert property (p_ackcs) else $error("ack busy");
  property p_oe; !d_oe_n |-> !cs_n && rd_n; endproperty
  a_oe: assert property (p_oe) else $error("drive clash");
  property p_rd; $fell(rd_n) |-> ##40 $rose(rd_n); endproperty
  a_rd: assert property (p_rd) else $error("rd width");
  property p_wr; $fell(wr_n) |-> ##40 $rose(wr_n); endproperty
  a_wr: assert property (p_wr) else $error("wr width");
  property p_ack; $fell(ack_n) |-> ##40 $rose(ack_n); endproperty
  a_ack: assert property (p_ack) else $error("ack width");
  property p_rsp; $rose(rd_n) |-> rsp_valid && rsp_index == 2'h0; endproperty
  a_rsp: assert property (p_rsp) else $error("no read byte");
  property p_cs; $fell(cs_n) |-> ##10 !(rd_n && wr_n); endproperty
  a_cs: assert property (p_cs) else $error("setup");
  c_third: cover property (rsp_valid && rsp_index == 2'h2);
  c_wr: cover property ($fell(wr_n));
  c_rd: cover property ($fell(rd_n));
endmodule : pic_host_checker
bind pic_host pic_host_checker i_chk (.mclk, .rst, .cs_n, .rd_n, .wr_n, .ack_n, .d_oe_n,
  .rsp_valid, .rsp_index);
`default_nettype wire

/* dv/pic_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_dev_model (
  input  wire logic       cs_n,                // Select.
  input  wire logic       rd_n,                // Read.
  input  wire logic       wr_n,                // Write.
  input  wire logic       addr_lsb,            // Address.
  input  wire logic       ack_n,               // Acknowledge.
  input  wire logic       mode85,              // Three-pulse mode.
  input  wire logic       auto_end_of_service, // Auto end.
  input  wire logic [7:0] request_inputs,      // Requests.
  input  wire logic [7:0] d_in,                // Bus level.
  output logic            int_in,              // Interrupt.
  output logic      [7:0] dev_q,               // Bus value.
  output logic      [2:0] slave_id_lines       // Cascade id.
);
  logic [7:0] pend = 8'h00, isv = 8'h00, mask = 8'hff, vec = 8'h00, init_cmd_word1 = 8'h00, rq = 8'h00;
  logic [2:0] lvl = 3'h7;
  logic [1:0] n = 2'h0;
  logic       sel_isr = 1'b0, want2 = 1'b0;
  function automatic logic [2:0] top(input logic [7:0] v);
    top = 3'h7;
    for (int i = 7; i >= 0; i--) if (v[i]) top = i[2:0];
  endfunction : top
  initial begin
    dev_q = 8'h5a;
    slave_id_lines = 3'h0;
  end
  assign int_in = |(pend & ~mask);
  always @(request_inputs) begin
    pend = pend | (request_inputs & ~rq);
    rq = request_inputs;
  end
  always @(negedge rd_n) if (!cs_n) dev_q = addr_lsb ? mask : sel_isr ? isv : pend;
  // A bus released by rd_n or ack_n shows the inverse, so a stale byte can never pass.
  always @(posedge rd_n or posedge ack_n) dev_q = ~dev_q;
  always @(negedge wr_n) if (!cs_n) begin
    casez ({addr_lsb, want2, d_in[4:3]})
      4'b0?1?: init_cmd_word1 = d_in;
      4'b11??: vec = d_in;
      4'b10??: mask = d_in;
      4'b0?01: sel_isr = d_in[0];
      default: if (d_in[5]) isv[top(isv)] = 1'b0;
    endcase
    want2 = !addr_lsb && d_in[4];
  end
  always @(negedge ack_n) begin
    n = n + 2'h1;
    if (n == 2'h1) lvl = top(pend & ~mask);
    if (n == 2'h1) slave_id_lines = lvl;
    if (n == (mode85 ? 2'h2 : 2'h1)) isv[lvl] = 1'b1;
    case ({mode85, n})
      3'b101: dev_q = 8'hcd;
      3'b110: dev_q = {init_cmd_word1[7:5], lvl, 2'h0};
      3'b111: dev_q = vec;
      3'b010: dev_q = {vec[7:3], lvl};
      default: dev_q = dev_q;
    endcase
  end
  always @(posedge ack_n) begin
    if (n == (mode85 ? 2'h2 : 2'h1)) pend[lvl] = 1'b0;
    if (n == (mode85 ? 2'h3 : 2'h2) && auto_end_of_service) isv[lvl] = 1'b0;
    if (n == (mode85 ? 2'h3 : 2'h2)) n = 2'h0;
  end
endmodule : pic_dev_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pic_pkg::*;
  logic       mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_addr = 1'b0;
  logic       mode85 = 1'b1, auto_end_of_service = 1'b0;
  logic [7:0] cmd_wdata = 8'h00, request_inputs = 8'h00;
  logic [7:0] rsp_data, d_out, dev_q, d_in;
  logic       cmd_ready, rsp_valid, int_seen, cs_n, rd_n, wr_n, addr_lsb, ack_n, d_oe_n, int_in;
  logic [1:0] rsp_index;
  logic [2:0] slave_id_lines;
  logic [7:0] got [3];
  pic_cmd_e   cmd_kind = pic_cmd_read;
  int         failures = 0, n_tests = 0, nrsp;
  assign d_in = d_oe_n ? dev_q : d_out;
  pic_host i_dut (
    .mclk      (mclk),      .rst       (rst),       .cmd_valid (cmd_valid),
    .cmd_kind  (cmd_kind),  .cmd_addr  (cmd_addr),  .cmd_wdata (cmd_wdata),
    .cmd_ready (cmd_ready), .rsp_valid (rsp_valid), .rsp_data  (rsp_data),
    .rsp_index (rsp_index), .int_seen  (int_seen),  .cs_n      (cs_n),
    .rd_n      (rd_n),      .wr_n      (wr_n),      .addr_lsb  (addr_lsb),
    .ack_n     (ack_n),     .d_in      (d_in),      .d_out     (d_out),
    .d_oe_n    (d_oe_n),    .int_in    (int_in)
  );
  pic_dev_model i_dev (
    .cs_n                (cs_n),           .rd_n                (rd_n),
    .wr_n                (wr_n),           .addr_lsb            (addr_lsb),
    .ack_n               (ack_n),          .mode85              (mode85),
    .auto_end_of_service (auto_end_of_service),
    .request_inputs      (request_inputs), .d_in                (d_in),
    .int_in              (int_in),         .dev_q               (dev_q),
    .slave_id_lines      (slave_id_lines)
  );
  initial forever #2 mclk = ~mclk;
  task automatic close_out;
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic op(input pic_cmd_e k, input logic a, input logic [7:0] w);
    int i;
    @(negedge mclk);
    cmd_kind = k;
    cmd_addr = a;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    nrsp = 0;
    for (i = 0; i < 400 && cmd_ready !== 1'b1; i++) begin
      if (rsp_valid === 1'b1) got[rsp_index] = rsp_data;
      if (rsp_valid === 1'b1) nrsp++;
      @(negedge mclk);
    end
    if (i == 400) failures++;
    if (i == 400) close_out();
  endtask : op
  task automatic rd(input string nm, input logic a, input logic [7:0] exp);
    op(pic_cmd_read, a, 8'h00);
    chk(nm, got[0], exp);
  endtask : rd
  task automatic t_init;
    op(pic_cmd_write, 1'h0, 8'hb3);
    op(pic_cmd_write, 1'h1, 8'h48);
    op(pic_cmd_write, 1'h1, 8'hf0);
    rd("mask", 1'h1, 8'hf0);
    op(pic_cmd_write, 1'h0, 8'h0a);
    rd("pending", 1'h0, 8'h00);
  endtask : t_init
  task automatic t_ack85;
    request_inputs = 8'h24;
    repeat (2) @(negedge mclk);
    chk("int", {7'h00, int_seen}, 8'h01);
    op(pic_cmd_ack85, 1'h0, 8'h00);
    chk("opcode", got[0], 8'hcd);
    chk("low", got[1], 8'ha8);
    chk("high", got[2], 8'h48);
    op(pic_cmd_write, 1'h0, 8'h0b);
    rd("in service", 1'h0, 8'h04);
    op(pic_cmd_write, 1'h0, 8'h0a);
    rd("pending", 1'h0, 8'h20);
    op(pic_cmd_write, 1'h0, 8'h20);
    op(pic_cmd_write, 1'h0, 8'h0b);
    rd("in service", 1'h0, 8'h00);
  endtask : t_ack85
  task automatic t_ack86;
    mode85 = 1'b0;
    auto_end_of_service = 1'b1;
    op(pic_cmd_write, 1'h1, 8'h00);
    op(pic_cmd_ack86, 1'h0, 8'h00);
    chk("count", 8'(nrsp), 8'h01);
    chk("vector", got[0], 8'h4d);
    chk("cascade", {5'h00, slave_id_lines}, 8'h05);
    rd("in service", 1'h0, 8'h00);
    op(pic_cmd_ack86, 1'h0, 8'h00);
    chk("spurious", got[0], 8'h4f);
    chk("spurious cascade", {5'h00, slave_id_lines}, 8'h07);
  endtask : t_ack86
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_init();
    t_ack85();
    t_ack86();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
